// ==== design/atc_cmd.sv ====
// Task-file command logic for feature setting and multiple mode.
// Assumes asynchronous host pins; all are synchronised before use.
// Functional notes
// - Opcode EF is feature setting: busy, latch feature, then ready and interrupt.
// - Unsupported or invalid feature code ends with aborted-command error.
// - Hard reset gives defaults of codes above 80, write cache aside.
// - After code 66, changed settings survive a software reset.
// - PIO mode 4 and multiword DMA mode 2 always usable.
// - Unsupported transfer-mode code aborts the command.
// - Mode code 00 selects default PIO.
// - Type 00001 is flow-control PIO, modes 0 to 4.
// - Type 00100 is multiword DMA, modes 0 to 2.
// - Type 01000 is Ultra DMA, modes 0 to 4.
// - Opcode C6 enables multi-sector commands and sets block count.
// - Accepted block counts are 2, 4, 8 and 16.
// - Busy while checking; valid count is stored and commands enabled.
// - Unsupported nonzero count aborts and disables multi-sector commands.
// - Count zero disables multi-sector commands.
// - Multiple-mode completion clears busy and raises interrupt.
// - Hard reset leaves multi-sector commands disabled.
// - Software reset keeps multiple-mode state and count.
// - Identify word 47 reads 8010, sixteen sectors maximum.
// - Identify word 59 is 0000 disabled, 01 plus count enabled.
`timescale 1ns/1ps
`include "atc_defs.svh"
module atc_cmd
  import atc_pkg::*;
#(
  parameter logic DRIVE_ID = 1'b0
)
(
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst,
  // Host task-file pins
  input  atc_pkg::atc_host_t     host_i,
  output logic [7:0]             dd_out,
  output logic                   dd_oe_n,
  output logic                   intrq,
  // Settings seen by the data engines
  output atc_pkg::atc_xfer_t     xfer_q,
  output atc_pkg::atc_feat_t     feat_q,
  output logic                   pio4_ok_q,
  output logic                   mdma2_ok_q,
  output logic                   mult_en_q,
  output logic [7:0]             mult_cnt_q,
  output logic                   mult_go_q,
  // Identify words
  output logic [15:0]            id_w47_q,
  output logic [15:0]            id_w59_q
);
  import atc_pkg::*;

  localparam logic [2:0] BUSY_CYC = 3'(`ATC_BUSY_CYC);

  atc_host_t  sync1_q, sync2_q, prev_q;
  atc_state_t state_q;
  logic [2:0] busy_cnt_q;
  logic [7:0] cmd_q, fr_q, sc_q, sn_q, cl_q, ch_q, dh_q, err_q;
  logic       err_st_q, abort_d;
  logic       wr_done, rd_start, sel, exec_end;
  atc_xfer_t  dec_xfer;
  logic       dec_ok;

  // Count of sectors per block that multiple mode accepts
  function automatic logic blk_ok(input logic [7:0] n);
    blk_ok = (n == 8'h02) || (n == 8'h04) || (n == 8'h08) || (n == 8'h10);
  endfunction

  // Feature codes this drive accepts, no-operation codes included
  function automatic logic feat_ok(input logic [7:0] f);
    unique case (f)
      `ATC_FC_WCACHE_ON, `ATC_FC_XFER_MODE, `ATC_FC_APM_ON, `ATC_FC_RCACHE_OFF,
      `ATC_FC_KEEP_SET, `ATC_FC_WCACHE_OFF, `ATC_FC_APM_OFF, `ATC_FC_RCACHE_ON,
      `ATC_FC_ECC4, `ATC_FC_REVERT,
      8'h04, 8'h33, 8'h54, 8'h77, 8'h81, 8'h84, 8'h88, 8'h89, 8'hAB:
        feat_ok = 1'b1;
      default:
        feat_ok = 1'b0;
    endcase
  endfunction

  function automatic logic at(input logic [2:0] a, input logic [8:0] ofs);
    at = (a == ofs[2:0]);
  endfunction

  // Two-stage synchroniser, then one more stage for edge detection
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      sync1_q <= '{cs_n: 1'b1, addr: 3'h0, rd_n: 1'b1, wr_n: 1'b1, data: 8'h00, srst: 1'b0};
      sync2_q <= '{cs_n: 1'b1, addr: 3'h0, rd_n: 1'b1, wr_n: 1'b1, data: 8'h00, srst: 1'b0};
      prev_q  <= '{cs_n: 1'b1, addr: 3'h0, rd_n: 1'b1, wr_n: 1'b1, data: 8'h00, srst: 1'b0};
    end
    else
    begin
      sync1_q <= host_i;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  // Writes land at the trailing edge, when address and data have settled
  assign wr_done  = sync2_q.wr_n && !prev_q.wr_n && !prev_q.cs_n && !sync2_q.srst;
  assign rd_start = !sync2_q.rd_n && prev_q.rd_n && !sync2_q.cs_n;
  assign sel      = (dh_q[`ATC_DH_DRV] == DRIVE_ID);
  assign exec_end = (state_q == ST_EXEC) && (busy_cnt_q == 3'h0);

  atc_xfer_dec u_dec (
    .code (sc_q),
    .xfer (dec_xfer),
    .ok   (dec_ok)
  );

  // Task-file parameter registers; frozen while busy
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      fr_q <= 8'h00;
      sc_q <= 8'h00;
      sn_q <= 8'h00;
      cl_q <= 8'h00;
      ch_q <= 8'h00;
      dh_q <= 8'h00;
    end
    else if (wr_done && state_q == ST_IDLE)
    begin
      if (at(prev_q.addr, `ATC_OFS_FEAT_ERR)) fr_q <= prev_q.data;
      if (at(prev_q.addr, `ATC_OFS_SECT_CNT)) sc_q <= prev_q.data;
      if (at(prev_q.addr, `ATC_OFS_SECT_NUM)) sn_q <= prev_q.data;
      if (at(prev_q.addr, `ATC_OFS_CYL_LOW))  cl_q <= prev_q.data;
      if (at(prev_q.addr, `ATC_OFS_CYL_HIGH)) ch_q <= prev_q.data;
      if (at(prev_q.addr, `ATC_OFS_DRV_HEAD)) dh_q <= prev_q.data;
    end
  end

  // Command sequencer: busy for a fixed check time, then complete
  always_ff @(posedge mclk)
  begin
    if (rst || sync2_q.srst)
    begin
      state_q    <= ST_IDLE;
      busy_cnt_q <= 3'h0;
      cmd_q      <= 8'h00;
    end
    else
    begin
      unique case (state_q)
        ST_IDLE:
        begin
          if (wr_done && sel && at(prev_q.addr, `ATC_OFS_CMD_STAT))
          begin
            state_q    <= ST_EXEC;
            busy_cnt_q <= BUSY_CYC - 3'h1;
            cmd_q      <= prev_q.data;
          end
        end
        ST_EXEC:
        begin
          if (busy_cnt_q == 3'h0)
            state_q <= ST_IDLE;
          else
            busy_cnt_q <= busy_cnt_q - 3'h1;
        end
      endcase
    end
  end

  // Outcome of the finishing command
  always_comb
  begin
    abort_d = 1'b0;
    unique case (cmd_q)
      `ATC_OP_SET_FEAT:
        abort_d = !feat_ok(fr_q) || (fr_q == `ATC_FC_XFER_MODE && !dec_ok);
      `ATC_OP_SET_MULT:
        abort_d = (sc_q != 8'h00) && !blk_ok(sc_q);
      `ATC_OP_RD_MULT, `ATC_OP_WR_MULT:
        abort_d = !mult_en_q;
      default:
        abort_d = 1'b1;
    endcase
  end

  // Error register and error status bit
  always_ff @(posedge mclk)
  begin
    if (rst || sync2_q.srst)
    begin
      err_q    <= 8'h00;
      err_st_q <= 1'b0;
    end
    else if (exec_end)
    begin
      err_q    <= abort_d ? (8'h01 << `ATC_ER_ABRT) : 8'h00;
      err_st_q <= abort_d;
    end
  end

  // Feature settings; soft reset reverts unless keeping was chosen
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      feat_q <= '{rcache: `ATC_RST_RCACHE, wcache: `ATC_RST_WCACHE, apm: `ATC_RST_APM,
                  ecc4: `ATC_RST_ECC4, revert: `ATC_RST_REVERT};
      xfer_q <= '{kind: XK_PIO_DEF, mode: 3'h0};
    end
    else if (sync2_q.srst && feat_q.revert)
    begin
      // Write cache keeps its value across soft reset
      feat_q.rcache <= `ATC_RST_RCACHE;
      feat_q.apm    <= `ATC_RST_APM;
      feat_q.ecc4   <= `ATC_RST_ECC4;
      xfer_q        <= '{kind: XK_PIO_DEF, mode: 3'h0};
    end
    else if (exec_end && cmd_q == `ATC_OP_SET_FEAT && !abort_d)
    begin
      unique case (fr_q)
        `ATC_FC_WCACHE_ON:  feat_q.wcache <= 1'b1;
        `ATC_FC_WCACHE_OFF: feat_q.wcache <= 1'b0;
        `ATC_FC_RCACHE_ON:  feat_q.rcache <= 1'b1;
        `ATC_FC_RCACHE_OFF: feat_q.rcache <= 1'b0;
        `ATC_FC_APM_ON:     feat_q.apm    <= 1'b1;
        `ATC_FC_APM_OFF:    feat_q.apm    <= 1'b0;
        `ATC_FC_ECC4:       feat_q.ecc4   <= 1'b1;
        `ATC_FC_KEEP_SET:   feat_q.revert <= 1'b0;
        `ATC_FC_REVERT:     feat_q.revert <= 1'b1;
        `ATC_FC_XFER_MODE:  xfer_q        <= dec_xfer;
        default:            feat_q        <= feat_q;
      endcase
    end
  end

  // Fixed capability, independent of any mode selection
  always_ff @(posedge mclk)
  begin
    pio4_ok_q  <= 1'b1;
    mdma2_ok_q <= 1'b1;
  end

  // Multiple-mode state; soft reset leaves it alone
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      mult_en_q  <= 1'b0;
      mult_cnt_q <= 8'h00;
    end
    else if (exec_end && cmd_q == `ATC_OP_SET_MULT)
    begin
      mult_en_q <= blk_ok(sc_q);
      if (blk_ok(sc_q))
        mult_cnt_q <= sc_q;
    end
  end

  // Start pulse for the multi-sector data engine
  always_ff @(posedge mclk)
  begin
    if (rst)
      mult_go_q <= 1'b0;
    else
      mult_go_q <= exec_end && !abort_d &&
                   (cmd_q == `ATC_OP_RD_MULT || cmd_q == `ATC_OP_WR_MULT);
  end

  // Identify words; word 59 carries the live block count
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      id_w47_q <= `ATC_ID_W47;
      id_w59_q <= `ATC_ID_W59_OFF;
    end
    else
    begin
      id_w47_q <= `ATC_ID_W47;
      id_w59_q <= mult_en_q ? {`ATC_ID_W59_EN, mult_cnt_q} : `ATC_ID_W59_OFF;
    end
  end

  // Interrupt: completion sets, status read or soft reset clears; set wins
  always_ff @(posedge mclk)
  begin
    if (rst)
      intrq <= 1'b0;
    else if (exec_end)
      intrq <= 1'b1;
    else if (sync2_q.srst || (rd_start && sel && at(sync2_q.addr, `ATC_OFS_CMD_STAT)))
      intrq <= 1'b0;
  end

  // Read data; only the selected drive drives the bus
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      dd_out  <= 8'h00;
      dd_oe_n <= 1'b1;
    end
    else
    begin
      dd_oe_n <= !(!sync2_q.rd_n && !sync2_q.cs_n && sel);
      if (rd_start)
      begin
        // Only the low three offset bits reach the pins
        unique case (sync2_q.addr)
          3'(`ATC_OFS_FEAT_ERR): dd_out <= err_q;
          3'(`ATC_OFS_SECT_CNT): dd_out <= sc_q;
          3'(`ATC_OFS_SECT_NUM): dd_out <= sn_q;
          3'(`ATC_OFS_CYL_LOW):  dd_out <= cl_q;
          3'(`ATC_OFS_CYL_HIGH): dd_out <= ch_q;
          3'(`ATC_OFS_DRV_HEAD): dd_out <= dh_q;
          3'(`ATC_OFS_CMD_STAT):
            dd_out <= ((state_q == ST_EXEC) ? 8'h80 : 8'h50) | {7'h00, err_st_q};
          default:               dd_out <= 8'h00;
        endcase
      end
    end
  end

  // Checks
  busy_len_a: assert property (@(posedge mclk) disable iff (rst)
    $rose(state_q == ST_EXEC) && !sync2_q.srst |-> (state_q == ST_EXEC)[*4] ##1 intrq)
    else $error("busy period or interrupt wrong");
  feat_abort_a: assert property (@(posedge mclk) disable iff (rst)
    exec_end && cmd_q == `ATC_OP_SET_FEAT && !feat_ok(fr_q) |=> err_q == 8'h04)
    else $error("bad feature not aborted");
  hard_dflt_a: assert property (@(posedge mclk)
    $past(rst) |-> feat_q.revert && feat_q.ecc4 && !mult_en_q)
    else $error("reset defaults wrong");
  keep_set_a: assert property (@(posedge mclk) disable iff (rst)
    !feat_q.revert && sync2_q.srst && !exec_end |=> $stable(xfer_q) && $stable(feat_q))
    else $error("kept settings reverted");
  xfer_bad_a: assert property (@(posedge mclk) disable iff (rst)
    exec_end && cmd_q == `ATC_OP_SET_FEAT && fr_q == 8'h03 && !dec_ok
    |=> err_st_q && $stable(xfer_q))
    else $error("bad mode code accepted");
  mult_set_a: assert property (@(posedge mclk) disable iff (rst)
    exec_end && cmd_q == `ATC_OP_SET_MULT && blk_ok(sc_q)
    |=> mult_en_q && mult_cnt_q == $past(sc_q) ##1 id_w59_q[15:8] == 8'h01)
    else $error("valid count not stored");
  mult_bad_a: assert property (@(posedge mclk) disable iff (rst)
    exec_end && cmd_q == `ATC_OP_SET_MULT && sc_q != 8'h00 && !blk_ok(sc_q)
    |=> !mult_en_q && err_st_q ##1 id_w59_q == 16'h0000)
    else $error("bad count not aborted");
  mult_off_a: assert property (@(posedge mclk) disable iff (rst)
    exec_end && cmd_q == `ATC_OP_SET_MULT && sc_q == 8'h00 |=> !mult_en_q && !err_st_q)
    else $error("zero count did not disable");
  mult_keep_a: assert property (@(posedge mclk) disable iff (rst)
    sync2_q.srst |=> $stable(mult_en_q) && $stable(mult_cnt_q))
    else $error("soft reset changed multiple mode");
  mult_rej_a: assert property (@(posedge mclk) disable iff (rst)
    exec_end && cmd_q == `ATC_OP_RD_MULT && !mult_en_q |=> !mult_go_q && err_st_q)
    else $error("disabled multiple command ran");
  sel_only_a: assert property (@(posedge mclk) disable iff (rst)
    !sel |-> dd_oe_n || $past(dh_q[`ATC_DH_DRV]) == DRIVE_ID)
    else $error("unselected drive drove bus");
  cv_feat_c: cover property (@(posedge mclk) exec_end && cmd_q == 8'hEF && !abort_d);
  cv_mult_c: cover property (@(posedge mclk) exec_end && cmd_q == 8'hC6 && sc_q == 8'h10);
  cv_keep_c: cover property (@(posedge mclk) !feat_q.revert && sync2_q.srst);

endmodule

// ==== design/atc_defs.svh ====
// Constants of the feature and multiple-mode command logic.
// Assumes a byte-wide task file at the legacy primary block.
`ifndef ATC_DEFS_SVH
`define ATC_DEFS_SVH

// Task-file offsets; the pins carry the low three bits
`define ATC_OFS_FEAT_ERR   9'h1F1
`define ATC_OFS_SECT_CNT   9'h1F2
`define ATC_OFS_SECT_NUM   9'h1F3
`define ATC_OFS_CYL_LOW    9'h1F4
`define ATC_OFS_CYL_HIGH   9'h1F5
`define ATC_OFS_DRV_HEAD   9'h1F6
`define ATC_OFS_CMD_STAT   9'h1F7

// Command opcodes
`define ATC_OP_SET_FEAT    8'hEF
`define ATC_OP_SET_MULT    8'hC6
`define ATC_OP_RD_MULT     8'hC4
`define ATC_OP_WR_MULT     8'hC5

// Feature codes with an effect
`define ATC_FC_WCACHE_ON   8'h02
`define ATC_FC_XFER_MODE   8'h03
`define ATC_FC_APM_ON      8'h05
`define ATC_FC_RCACHE_OFF  8'h55
`define ATC_FC_KEEP_SET    8'h66
`define ATC_FC_WCACHE_OFF  8'h82
`define ATC_FC_APM_OFF     8'h85
`define ATC_FC_RCACHE_ON   8'hAA
`define ATC_FC_ECC4        8'hBB
`define ATC_FC_REVERT      8'hCC

// Transfer-mode type fields and highest mode numbers
`define ATC_XT_PIO_DEF     5'h00
`define ATC_XT_PIO_FC      5'h01
`define ATC_XT_MDMA        5'h04
`define ATC_XT_UDMA        5'h08
`define ATC_XM_PIO_MAX     3'h4
`define ATC_XM_MDMA_MAX    3'h2
`define ATC_XM_UDMA_MAX    3'h4

// Status, error and drive/head bit positions
`define ATC_ST_BSY         7
`define ATC_ST_DRDY        6
`define ATC_ST_DSC         4
`define ATC_ST_ERR         0
`define ATC_ER_ABRT        2
`define ATC_DH_DRV         4

// Identify words for multiple mode
`define ATC_ID_W47         16'h8010
`define ATC_ID_W59_EN      8'h01
`define ATC_ID_W59_OFF     16'h0000

// Power-on feature defaults
`define ATC_RST_RCACHE     1'b1
`define ATC_RST_WCACHE     1'b1
`define ATC_RST_APM        1'b0
`define ATC_RST_ECC4       1'b1
`define ATC_RST_REVERT     1'b1

// Timing
`define ATC_CLK_NS         25
`define ATC_BUSY_NS        100
`define ATC_BUSY_CYC       ((`ATC_BUSY_NS + `ATC_CLK_NS - 1) / `ATC_CLK_NS)

`endif

// ==== design/atc_pkg.sv ====
// Types shared by the feature and multiple-mode command logic.
// Assumes the constants header is included where numbers are needed.
package atc_pkg;

  // Host pins of the task-file port
  typedef struct packed {
    logic       cs_n;
    logic [2:0] addr;
    logic       rd_n;
    logic       wr_n;
    logic [7:0] data;
    logic       srst;
  } atc_host_t;

  typedef enum logic [1:0] {XK_PIO_DEF, XK_PIO_FC, XK_MDMA, XK_UDMA} atc_xkind_t;

  typedef struct packed {
    atc_xkind_t kind;
    logic [2:0] mode;
  } atc_xfer_t;

  typedef struct packed {
    logic rcache;
    logic wcache;
    logic apm;
    logic ecc4;
    logic revert;
  } atc_feat_t;

  typedef enum logic {ST_IDLE, ST_EXEC} atc_state_t;

endpackage

// ==== design/atc_xfer_dec.sv ====
// Decoder of the transfer-mode code carried in the sector count.
// Assumes the code is stable for the cycle in which it is used.
`timescale 1ns/1ps
`include "atc_defs.svh"
module atc_xfer_dec
  import atc_pkg::*;
(
  // Mode code
  input  wire logic [7:0]        code,
  // Decoded result
  output atc_pkg::atc_xfer_t     xfer,
  output logic                   ok
);

  // Upper five bits pick the type, lower three the mode number
  always_comb
  begin
    xfer.mode = code[2:0];
    xfer.kind = XK_PIO_DEF;
    ok        = 1'b0;
    unique case (code[7:3])
      `ATC_XT_PIO_DEF:
      begin
        ok = (code[2:0] == 3'h0);
      end
      `ATC_XT_PIO_FC:
      begin
        xfer.kind = XK_PIO_FC;
        ok        = (code[2:0] <= `ATC_XM_PIO_MAX);
      end
      `ATC_XT_MDMA:
      begin
        xfer.kind = XK_MDMA;
        ok        = (code[2:0] <= `ATC_XM_MDMA_MAX);
      end
      `ATC_XT_UDMA:
      begin
        xfer.kind = XK_UDMA;
        ok        = (code[2:0] <= `ATC_XM_UDMA_MAX);
      end
      default:
      begin
        ok = 1'b0;
      end
    endcase
  end

endmodule

// ==== tb/atc_host_model.sv ====
// Host side of the task-file port: pin-level write, read and soft reset.
// Assumes the device synchronises the pins; pins move at falling edges.
`timescale 1ns/1ps
module atc_host_model
  import atc_pkg::*;
(
  // Clock
  input  wire logic          mclk,
  // Pins toward the device
  output atc_pkg::atc_host_t host_o,
  input  wire logic [7:0]    dd_out,
  input  wire logic          dd_oe_n
);
  // Strobe length in cycles; raised by the bench to act as a slow host
  int gap = 4;

  // Idle pins at time zero
  initial host_o = '{1'b1, 3'h0, 1'b1, 1'b1, 8'h00, 1'b0};

  // Address and data stay put across the whole strobe and its sync delay
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge mclk);
    host_o.cs_n = 1'b0;
    host_o.addr = a;
    host_o.data = d;
    repeat (gap) @(negedge mclk);
    host_o.wr_n = 1'b0;
    repeat (gap) @(negedge mclk);
    host_o.wr_n = 1'b1;
    repeat (gap) @(negedge mclk);
    host_o.cs_n = 1'b1;
    host_o.data = ~d; // Released bus must not show a stale byte
  endtask

  // Data taken late in the strobe, after the sync delay has passed
  task automatic rd(input logic [2:0] a, output logic [7:0] d, output logic oe);
    @(negedge mclk);
    host_o.cs_n = 1'b0;
    host_o.addr = a;
    repeat (gap) @(negedge mclk);
    host_o.rd_n = 1'b0;
    repeat (gap + 2) @(negedge mclk);
    oe = ~dd_oe_n;
    d = dd_oe_n ? ~dd_out : dd_out; // Undriven bus reads as noise
    host_o.rd_n = 1'b1;
    repeat (gap) @(negedge mclk);
    host_o.cs_n = 1'b1;
  endtask

  // Soft reset level held long enough to pass the synchroniser
  task automatic soft_reset();
    @(negedge mclk);
    host_o.srst = 1'b1;
    repeat (gap + 2) @(negedge mclk);
    host_o.srst = 1'b0;
    repeat (gap + 2) @(negedge mclk);
  endtask
endmodule

// ==== tb/tb_ata_transfer_mode_and_multiple_cfg.sv ====
// Self-checking bench of the feature and multiple-mode command logic.
// Assumes the host model for pin cycles and DRIVE_ID left at 0.
`timescale 1ns/1ps
`include "atc_defs.svh"
module tb_ata_transfer_mode_and_multiple_cfg;
  import atc_pkg::*;
  localparam int LIMIT = 95000;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  atc_host_t   host;
  logic [7:0]  dd_out, mult_cnt_q, st, v;
  logic        dd_oe_n, intrq, pio4_ok_q, mdma2_ok_q, mult_en_q, mult_go_q, oe, ok;
  atc_xfer_t   xfer_q;
  atc_feat_t   feat_q, fe;
  logic [15:0] id_w47_q, id_w59_q;
  logic [4:0]  xe;
  logic [7:0]  ce;
  logic        me, ck;
  int          fails = 0, checks_done = 0, cyc = 0, go_cnt = 0;
  int          seed = 32'h853b52b5;

  atc_cmd dut_u (.mclk(mclk), .rst(rst), .host_i(host), .dd_out(dd_out),
    .dd_oe_n(dd_oe_n), .intrq(intrq), .xfer_q(xfer_q), .feat_q(feat_q),
    .pio4_ok_q(pio4_ok_q), .mdma2_ok_q(mdma2_ok_q), .mult_en_q(mult_en_q),
    .mult_cnt_q(mult_cnt_q), .mult_go_q(mult_go_q), .id_w47_q(id_w47_q),
    .id_w59_q(id_w59_q));
  atc_host_model host_u (.mclk(mclk), .host_o(host), .dd_out(dd_out), .dd_oe_n(dd_oe_n));

  // Clock and reset
  initial forever #12.5 mclk = ~mclk;
  initial
  begin
    repeat (8) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
  end

  // Pulses counted mid-cycle so the launching edge has settled
  always @(negedge mclk)
  begin
    cyc++;
    if (mult_go_q === 1'b1) go_cnt++;
    if (cyc == LIMIT)
    begin
      fails++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_word({15'h0000, got}, {15'h0000, exp});
  endtask

  // Expectation helpers built from the code tables
  function automatic logic feat_ok(input logic [7:0] fc);
    return fc inside {8'h02, 8'h03, 8'h04, 8'h05, 8'h33, 8'h54, 8'h55, 8'h66, 8'h77,
      8'h81, 8'h82, 8'h84, 8'h85, 8'h88, 8'h89, 8'hAA, 8'hAB, 8'hBB, 8'hCC};
  endfunction

  function automatic logic xfer_ok(input logic [7:0] c);
    case (c[7:3])
      5'h00: return c[2:0] == 3'h0;
      5'h01, 5'h08: return c[2:0] <= 3'h4;
      5'h04: return c[2:0] <= 3'h2;
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic [4:0] xfer_of(input logic [7:0] c);
    case (c[7:3])
      5'h01: return {XK_PIO_FC, c[2:0]};
      5'h04: return {XK_MDMA, c[2:0]};
      5'h08: return {XK_UDMA, c[2:0]};
      default: return {XK_PIO_DEF, 3'h0};
    endcase
  endfunction

  // Bounded wait; leaves early once the interrupt shows
  task automatic wait_irq(output logic hit);
    hit = 1'b0;
    for (int i = 0; i < 40 && hit !== 1'b1; i++)
    begin
      @(negedge mclk);
      if (intrq === 1'b1) hit = 1'b1;
    end
  endtask

  // Parameters, then drive/head, then opcode; completion read back
  task automatic do_cmd(input logic [7:0] fc, sc, op, input logic bad);
    host_u.wr(3'h1, fc);
    host_u.wr(3'h2, sc);
    host_u.wr(3'h6, 8'($random(seed)) & 8'hEF);
    host_u.wr(3'h7, op);
    wait_irq(ok);
    chk_bit(ok, 1'b1);
    host_u.rd(3'h7, st, oe);
    chk_word(16'(st), bad ? 16'h0051 : 16'h0050);
    chk_bit(intrq, 1'b0);
    if (bad)
    begin
      host_u.rd(3'h1, st, oe);
      chk_word(16'(st), 16'h0004);
    end
  endtask

  task automatic check_feat();
    chk_word(16'(xfer_q), 16'(xe));
    chk_word(16'(feat_q), 16'(fe));
  endtask

  task automatic set_feat(input logic [7:0] fc, sc);
    logic bad;
    bad = !feat_ok(fc) || (fc == 8'h03 && !xfer_ok(sc));
    do_cmd(fc, sc, `ATC_OP_SET_FEAT, bad);
    case (bad ? 8'h00 : fc)
      8'h02: fe.wcache = 1'b1;
      8'h82: fe.wcache = 1'b0;
      8'h05: fe.apm = 1'b1;
      8'h85: fe.apm = 1'b0;
      8'h55: fe.rcache = 1'b0;
      8'hAA: fe.rcache = 1'b1;
      8'hBB: fe.ecc4 = 1'b1;
      8'h66: fe.revert = 1'b0;
      8'hCC: fe.revert = 1'b1;
      8'h03: xe = xfer_of(sc);
      default: ;
    endcase
    check_feat();
  endtask

  // Soft reset: defaults return only while reverting is on
  task automatic soft_rst();
    host_u.soft_reset();
    if (fe.revert)
    begin
      fe.rcache = 1'b1;
      fe.apm = 1'b0;
      fe.ecc4 = 1'b1;
      xe = {XK_PIO_DEF, 3'h0};
    end
    check_feat();
    chk_bit(mult_en_q, me);
    if (ck) chk_word(16'(mult_cnt_q), 16'(ce));
  endtask

  task automatic set_mult(input logic [7:0] sc);
    logic good;
    good = sc inside {8'h02, 8'h04, 8'h08, 8'h10};
    do_cmd(8'($random(seed)), sc, `ATC_OP_SET_MULT, !good && sc != 8'h00);
    me = good;
    ck = good || (ck && sc != 8'h00);
    if (good) ce = sc;
    chk_bit(mult_en_q, me);
    if (ck) chk_word(16'(mult_cnt_q), 16'(ce));
    chk_word(id_w59_q, me ? {8'h01, ce} : 16'h0000);
  endtask

  // Multi-sector opcode: refused while disabled, else handed on once
  task automatic mult_rw(input logic [7:0] op);
    int g;
    g = go_cnt;
    if (!me)
      do_cmd(8'h00, 8'h01, op, 1'b1);
    else
    begin
      host_u.wr(3'h6, 8'h00);
      host_u.wr(3'h7, op);
      repeat (20) @(negedge mclk);
      soft_rst();
    end
    chk_word(16'(go_cnt - g), me ? 16'h0001 : 16'h0000);
  endtask

  initial
  begin
    fe = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
    xe = {XK_PIO_DEF, 3'h0};
    me = 1'b0;
    ce = 8'h00;
    ck = 1'b1;
    wait (rst == 1'b0);
    repeat (2) @(negedge mclk);
    // Power-on state
    check_feat();
    chk_bit(pio4_ok_q & mdma2_ok_q, 1'b1);
    chk_bit(mult_en_q, 1'b0);
    chk_word(id_w47_q, 16'h8010);
    chk_word(id_w59_q, 16'h0000);
    host_u.rd(3'h7, st, oe);
    chk_word(16'(st), 16'h0050);
    // Parameter registers read back what was written
    for (int a = 2; a < 6; a++)
    begin
      v = 8'($random(seed));
      host_u.wr(3'(a), v);
      host_u.rd(3'(a), st, oe);
      chk_word(16'(st), 16'(v));
    end
    // Every feature code, then every transfer-mode code
    for (int f = 0; f < 256; f++) set_feat(8'(f), 8'($random(seed)));
    for (int c = 0; c < 256; c++) set_feat(8'h03, 8'(c));
    // Reverting on, then off with a slow host
    set_feat(8'h55, 8'h00);
    set_feat(8'h05, 8'h00);
    set_feat(8'h82, 8'h00);
    set_feat(8'h03, 8'h42);
    set_mult(8'h08);
    soft_rst();
    host_u.gap = 8;
    set_feat(8'h66, 8'h00);
    set_feat(8'h55, 8'h00);
    set_feat(8'h03, 8'h22);
    soft_rst();
    host_u.gap = 4;
    // Block counts: corners, then random even values
    for (int i = 0; i < 8; i++) set_mult(8'(8'h01 << i));
    set_mult(8'h00);
    mult_rw(`ATC_OP_RD_MULT);
    mult_rw(`ATC_OP_WR_MULT);
    // Opcode outside this block still completes, with an abort
    do_cmd(8'h00, 8'h00, 8'h00, 1'b1);
    set_mult(8'h03);
    for (int r = 0; r < 30; r++) set_mult(8'($random(seed)) & 8'h1E);
    set_mult(8'h02);
    mult_rw(`ATC_OP_RD_MULT);
    mult_rw(`ATC_OP_WR_MULT);
    // Other drive selected: no execution, no answer
    host_u.wr(3'h2, 8'h04);
    host_u.wr(3'h6, 8'h10);
    host_u.wr(3'h7, `ATC_OP_SET_MULT);
    wait_irq(ok);
    chk_bit(ok, 1'b0);
    host_u.rd(3'h7, st, oe);
    chk_bit(oe, 1'b0);
    chk_word(16'(mult_cnt_q), 16'(ce));
    print_verdict();
  end
endmodule
